// ===== rtl/iopc_map.svh
`ifndef IOPC_MAP_SVH
`define IOPC_MAP_SVH
// Register byte addresses (low 16 bits of the bus address)
`define IOPC_P3_DATA_ADDR 16'hFFD6
`define IOPC_P3_DIR_ADDR 16'hFFE6
`define IOPC_P3_PULL_ADDR 16'hFFEE
`define IOPC_P3_FUNC_ADDR 16'hFFFD
`define IOPC_SER_CTRL_ADDR 16'hFFF0
`define IOPC_MODE_ADDR 16'hFFF4
`define IOPC_P5_DATA_ADDR 16'hFFD8
`define IOPC_P5_DIR_ADDR 16'hFFE8
`define IOPC_P5_PULL_ADDR 16'hFFEF
// Reset values and read constants
`define IOPC_RST_8 8'h00
`define IOPC_RST_3 3'h0
`define IOPC_RST_1 1'b0
`define IOPC_DIR_READ 32'h000000FF
`define IOPC_ZERO_32 32'h00000000
// Field positions
`define IOPC_FS_CLK 0
`define IOPC_FS_IN 1
`define IOPC_FS_OUT 2
`define IOPC_SC_CKSRC 0
`endif

// ===== rtl/iopc_pkg.sv
package iopc_pkg;
  // Operating modes of the chip, one-hot
  typedef enum logic [6:0] {
    IOPC_ACTIVE = 7'h01,
    IOPC_SUBACTIVE = 7'h02,
    IOPC_SLEEP = 7'h04,
    IOPC_SUBSLEEP = 7'h08,
    IOPC_WATCH = 7'h10,
    IOPC_STANDBY = 7'h20,
    IOPC_RESET = 7'h40
  } iopc_mode_t;
  // Serial channel side signals toward the pin mux
  typedef struct packed {
    logic sdata_out;
    logic sclk_out;
    logic sclk_src;
  } iopc_ser_tx_t;
  typedef struct packed {
    logic sdata_in;
    logic sclk_in;
  } iopc_ser_rx_t;
  // Pin drive bundle
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull;
  } iopc_pins_t;
endpackage

// ===== rtl/iopc_port.sv
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/10ps
`include "iopc_map.svh"
// How it works
// - Pin 2: serial out, else general I/O
// - Pin 1: serial in, else general I/O
// - Pin 0: serial clock out/in, else I/O
// - Reset high-Z; sleep, subsleep and watch hold state
// - Standby high-Z, pulled-up pins show high
// - Port3 pull-up only when input and enabled
// - Port5 data, direction, pull-up registers mapped
// - Port5 read: latch if output, else pin
// - Port5 direction one drives latch out
// - Port5 direction reads all ones
// - Port5 data and direction reset zero
// - Port3 read: latch if output, else pin
// - Port5 pull-up only when input and enabled
module iopc_port import iopc_pkg::*; (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // Avalon-MM slave
  input wire logic [15:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Serial channel
  input wire iopc_ser_tx_t ser_tx_i,
  output iopc_ser_rx_t ser_rx_o,
  // Three-pin port
  input wire logic [2:0] p3_pin_i,
  output logic [2:0] p3_pin_o,
  output logic [2:0] p3_pin_oe_o,
  output logic [2:0] p3_pullup_o,
  // Eight-pin port
  input wire logic [7:0] p5_pin_i,
  output logic [7:0] p5_pin_o,
  output logic [7:0] p5_pin_oe_o,
  output logic [7:0] p5_pullup_o
);

  // Register state
  logic [2:0] port3_data;
  logic [2:0] port3_direction;
  logic [2:0] port3_pullup_ctrl;
  logic [2:0] port3_function_select;
  logic serial1_clk_source;
  iopc_mode_t op_mode;
  logic [7:0] port5_data_latch;
  logic [7:0] port5_direction_ctrl;
  logic [7:0] port5_pullup_enable;
  // Handshake state: high in the cycle after a request is taken
  logic ack;
  // Pin state frozen while the chip is not running
  iopc_pins_t p3_held;
  iopc_pins_t p5_held;

  // Live pin drive, before mode gating
  wire logic [2:0] p3_out_w;
  wire logic [2:0] p3_oe_w;
  wire logic [2:0] p3_pull_w;
  wire logic [7:0] p5_out_w;
  wire logic [7:0] p5_oe_w;
  wire logic [7:0] p5_pull_w;
  iopc_pins_t p3_live;
  iopc_pins_t p5_live;
  iopc_pins_t p3_pins;
  iopc_pins_t p5_pins;

  // Bus handshake terms; a request is taken in its first cycle only
  wire logic req = avs_read_i | avs_write_i;
  wire logic take = req & ~ack;
  wire logic rd_take = avs_read_i & ~ack;
  wire logic wr = avs_write_i & ~ack;
  wire logic [7:0] wd = avs_writedata_i[7:0];

  // Address decode
  wire logic hit_p3d = avs_address_i == `IOPC_P3_DATA_ADDR;
  wire logic hit_p3c = avs_address_i == `IOPC_P3_DIR_ADDR;
  wire logic hit_p3u = avs_address_i == `IOPC_P3_PULL_ADDR;
  wire logic hit_p3f = avs_address_i == `IOPC_P3_FUNC_ADDR;
  wire logic hit_sc = avs_address_i == `IOPC_SER_CTRL_ADDR;
  wire logic hit_md = avs_address_i == `IOPC_MODE_ADDR;
  wire logic hit_p5d = avs_address_i == `IOPC_P5_DATA_ADDR;
  wire logic hit_p5c = avs_address_i == `IOPC_P5_DIR_ADDR;
  wire logic hit_p5u = avs_address_i == `IOPC_P5_PULL_ADDR;

  // Write strobes, one per register
  wire logic we_p3d = wr & hit_p3d;
  wire logic we_p3c = wr & hit_p3c;
  wire logic we_p3u = wr & hit_p3u;
  wire logic we_p3f = wr & hit_p3f;
  wire logic we_sc = wr & hit_sc;
  wire logic we_md = wr & hit_md;
  wire logic we_p5d = wr & hit_p5d;
  wire logic we_p5c = wr & hit_p5c;
  wire logic we_p5u = wr & hit_p5u;

  // Function selects per pin
  wire logic fs_out = port3_function_select[`IOPC_FS_OUT];
  wire logic fs_in = port3_function_select[`IOPC_FS_IN];
  wire logic fs_clk = port3_function_select[`IOPC_FS_CLK];

  // Mode decode; sleep, subsleep, watch and reset codes hold the pins
  wire logic run = (op_mode == IOPC_ACTIVE) | (op_mode == IOPC_SUBACTIVE);
  wire logic stby = op_mode == IOPC_STANDBY;

  // Read-back values: latch for outputs, live pin for inputs
  wire logic [2:0] p3_read =
    (port3_data & port3_direction) | (p3_pin_i & ~port3_direction);
  wire logic [7:0] p5_read =
    (port5_data_latch & port5_direction_ctrl) | (p5_pin_i & ~port5_direction_ctrl);

  // Read words per register, zero-extended to the bus width
  wire logic [31:0] rw_p3d = {29'h0, p3_read};
  wire logic [31:0] rw_p3u = {29'h0, port3_pullup_ctrl};
  wire logic [31:0] rw_p3f = {29'h0, port3_function_select};
  wire logic [31:0] rw_sc = {31'h0, serial1_clk_source};
  wire logic [31:0] rw_md = {25'h0, op_mode};
  wire logic [31:0] rw_p5d = {24'h0, p5_read};
  wire logic [31:0] rw_p5u = {24'h0, port5_pullup_enable};
  // Both direction registers are write-only and read all ones
  wire logic [31:0] rw_dir = `IOPC_DIR_READ;

  // Read select; addresses are distinct, so at most one term is live
  wire logic [31:0] rdata =
    ({32{hit_p3d}} & rw_p3d) |
    ({32{hit_p3c}} & rw_dir) |
    ({32{hit_p3u}} & rw_p3u) |
    ({32{hit_p3f}} & rw_p3f) |
    ({32{hit_sc}} & rw_sc) |
    ({32{hit_md}} & rw_md) |
    ({32{hit_p5d}} & rw_p5d) |
    ({32{hit_p5c}} & rw_dir) |
    ({32{hit_p5u}} & rw_p5u);

  // One wait state: waitrequest high in the first cycle only
  assign avs_waitrequest_o = take;

  // Acknowledge flag, set by the edge that takes a request
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack <= `IOPC_RST_1;
    end else begin
      ack <= take;
    end
  end

  // Read data captured at the taking edge, held until the next read
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      avs_readdata_o <= `IOPC_ZERO_32;
    end else if (rd_take) begin
      avs_readdata_o <= rdata;
    end
  end

  // Three-pin output latch
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      port3_data <= `IOPC_RST_3;
    end else if (we_p3d) begin
      port3_data <= wd[2:0];
    end
  end

  // Three-pin direction
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      port3_direction <= `IOPC_RST_3;
    end else if (we_p3c) begin
      port3_direction <= wd[2:0];
    end
  end

  // Three-pin pull-up enables
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      port3_pullup_ctrl <= `IOPC_RST_3;
    end else if (we_p3u) begin
      port3_pullup_ctrl <= wd[2:0];
    end
  end

  // Three-pin function selects
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      port3_function_select <= `IOPC_RST_3;
    end else if (we_p3f) begin
      port3_function_select <= wd[2:0];
    end
  end

  // Serial clock source
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      serial1_clk_source <= `IOPC_RST_1;
    end else if (we_sc) begin
      serial1_clk_source <= wd[`IOPC_SC_CKSRC];
    end
  end

  // Operating mode; a non one-hot code holds the pins like sleep
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      op_mode <= IOPC_ACTIVE;
    end else if (we_md) begin
      op_mode <= iopc_mode_t'(wd[6:0]);
    end
  end

  // Eight-pin output latch
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      port5_data_latch <= `IOPC_RST_8;
    end else if (we_p5d) begin
      port5_data_latch <= wd;
    end
  end

  // Eight-pin direction, write-only
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      port5_direction_ctrl <= `IOPC_RST_8;
    end else if (we_p5c) begin
      port5_direction_ctrl <= wd;
    end
  end

  // Eight-pin pull-up enables
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      port5_pullup_enable <= `IOPC_RST_8;
    end else if (we_p5u) begin
      port5_pullup_enable <= wd;
    end
  end

  // Pin 2: serial data out when selected, else general I/O
  assign p3_out_w[2] = fs_out ? ser_tx_i.sdata_out : port3_data[2];
  assign p3_oe_w[2] = fs_out | port3_direction[2];
  // Pin 1: serial data in when selected, so never driven then
  assign p3_out_w[1] = port3_data[1];
  assign p3_oe_w[1] = ~fs_in & port3_direction[1];
  // Pin 0: serial clock out or in when selected, else general I/O
  assign p3_out_w[0] = fs_clk ? ser_tx_i.sclk_out : port3_data[0];
  assign p3_oe_w[0] = fs_clk ? ~ser_tx_i.sclk_src : port3_direction[0];

  // Pull-up per pin: only an undriven pin with its direction bit clear and its enable bit set
  for (genvar n = 0; n < 3; n++) begin : g_p3_pull
    assign p3_pull_w[n] =
      ~p3_oe_w[n] & ~port3_direction[n] & port3_pullup_ctrl[n];
  end

  // Eight-pin port: each direction bit picks output or input per pin
  for (genvar i = 0; i < 8; i++) begin : g_p5_pin
    assign p5_out_w[i] = port5_data_latch[i];
    assign p5_oe_w[i] = port5_direction_ctrl[i];
    assign p5_pull_w[i] = ~port5_direction_ctrl[i] & port5_pullup_enable[i];
  end

  // Live bundles, padded to the shared pin width
  assign p3_live = {5'h00, p3_out_w, 5'h00, p3_oe_w, 5'h00, p3_pull_w};
  assign p5_live = {p5_out_w, p5_oe_w, p5_pull_w};

  // Serial inputs returned from the pins
  assign ser_rx_o.sdata_in = p3_pin_i[1];
  assign ser_rx_o.sclk_in = p3_pin_i[0];

  // Three-pin snapshot, frozen outside the run modes
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      p3_held <= '0;
    end else if (run) begin
      p3_held <= p3_live;
    end
  end

  // Eight-pin snapshot, frozen outside the run modes
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      p5_held <= '0;
    end else if (run) begin
      p5_held <= p5_live;
    end
  end

  // Standby: float, pulled-up pins driven high
  function automatic iopc_pins_t stby_pins(input iopc_pins_t p);
    iopc_pins_t s;
    s.out = p.pull;
    s.oe = p.pull;
    s.pull = p.pull;
    return s;
  endfunction

  assign p3_pins = stby ? stby_pins(p3_held) : (run ? p3_live : p3_held);
  assign p5_pins = stby ? stby_pins(p5_held) : (run ? p5_live : p5_held);

  // Three-pin drive value
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      p3_pin_o <= `IOPC_RST_3;
    end else begin
      p3_pin_o <= p3_pins.out[2:0];
    end
  end

  // Three-pin enables; reset leaves every pin floating
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      p3_pin_oe_o <= `IOPC_RST_3;
    end else begin
      p3_pin_oe_o <= p3_pins.oe[2:0];
    end
  end

  // Three-pin pull-ups, off after reset
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      p3_pullup_o <= `IOPC_RST_3;
    end else begin
      p3_pullup_o <= p3_pins.pull[2:0];
    end
  end

  // Eight-pin drive value
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      p5_pin_o <= `IOPC_RST_8;
    end else begin
      p5_pin_o <= p5_pins.out;
    end
  end

  // Eight-pin enables; reset leaves every pin floating
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      p5_pin_oe_o <= `IOPC_RST_8;
    end else begin
      p5_pin_oe_o <= p5_pins.oe;
    end
  end

  // Eight-pin pull-ups, off after reset
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      p5_pullup_o <= `IOPC_RST_8;
    end else begin
      p5_pullup_o <= p5_pins.pull;
    end
  end

endmodule // iopc_port

// ===== verif/iopc_port_chk.sv
`timescale 1ns/10ps
module iopc_port_chk import iopc_pkg::*; (
  // Clock, reset and bus
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic [15:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Pins
  input wire iopc_ser_rx_t ser_rx_o,
  input wire logic [2:0] p3_pin_i,
  input wire logic [2:0] p3_pin_oe_o,
  input wire logic [7:0] p5_pin_oe_o,
  input wire logic [7:0] p5_pullup_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  // Completing read
  wire rd_ok = avs_read_i && !avs_waitrequest_o;
  a_one_wait: assert property ($rose(avs_read_i || avs_write_i) |->
    avs_waitrequest_o ##1 !avs_waitrequest_o) else $error("wait state count");
  a_idle_nowait: assert property (!(avs_read_i || avs_write_i) |->
    !avs_waitrequest_o) else $error("wait without request");
  a_dir5_ones: assert property (rd_ok && avs_address_i == 16'hFFE8 |->
    avs_readdata_o == 32'h000000FF) else $error("port5 direction read");
  a_dir3_ones: assert property (rd_ok && avs_address_i == 16'hFFE6 |->
    avs_readdata_o == 32'h000000FF) else $error("port3 direction read");
  a_rx_route: assert property (ser_rx_o == {p3_pin_i[1], p3_pin_i[0]})
    else $error("serial inputs not routed");
  a_pull5_in: assert property ((p5_pullup_o & p5_pin_oe_o) == 8'h00)
    else $error("pull-up on driven pin");
  a_rst_hiz: assert property ($rose(rstn_i) |->
    p3_pin_oe_o == 3'h0 && p5_pin_oe_o == 8'h00) else $error("pins driven at reset");
  a_oe5_cause: assert property (!$stable(p5_pin_oe_o) |->
    $past(avs_write_i, 2)) else $error("enable moved without write");
  c_read: cover property (rd_ok && avs_address_i == 16'hFFD8);
  c_write: cover property (avs_write_i && !avs_waitrequest_o);
  c_pull: cover property (p5_pullup_o != 8'h00);
endmodule // iopc_port_chk
bind iopc_port iopc_port_chk u_chk (.mclk_i, .rstn_i, .avs_address_i, .avs_read_i,
  .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .ser_rx_o, .p3_pin_i, .p3_pin_oe_o,
  .p5_pin_oe_o, .p5_pullup_o);

// ===== verif/iopc_board.sv
`timescale 1ns/10ps
module iopc_board #(parameter int W = 8) (
  // Pad drive and outside source
  input wire logic [W-1:0] ext_i,
  input wire logic [W-1:0] out_i,
  input wire logic [W-1:0] oe_i,
  input wire logic [W-1:0] pull_i,
  // Resolved level
  output logic [W-1:0] lvl_o
);
  // Pad wins, then pull-up, then the outside source
  assign lvl_o = (oe_i & out_i) | (~oe_i & (pull_i | ext_i));
endmodule // iopc_board

// ===== verif/iopc_port_tb_top.sv
`timescale 1ns/10ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module iopc_port_tb_top import iopc_pkg::*; ;
  logic mclk_i = 0, rstn_i = 0, rd = 0, wr = 0, wq;
  logic [15:0] adr = 16'h0000;
  logic [31:0] wd = 32'h00000000, rdat;
  logic [7:0] q, ext5 = 8'h00, p5o, p5e, p5u, p5l;
  logic [2:0] ext3 = 3'h0, p3o, p3e, p3u, p3l;
  iopc_ser_tx_t stx = 3'h0;
  iopc_ser_rx_t srx;
  int err_total = 0, tests_run = 0;
  // Device and board
  iopc_port uut (.mclk_i, .rstn_i, .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_readdata_o(rdat), .avs_waitrequest_o(wq), .ser_tx_i(stx),
    .ser_rx_o(srx), .p3_pin_i(p3l), .p3_pin_o(p3o), .p3_pin_oe_o(p3e), .p3_pullup_o(p3u),
    .p5_pin_i(p5l), .p5_pin_o(p5o), .p5_pin_oe_o(p5e), .p5_pullup_o(p5u));
  iopc_board #(.W(3)) b3 (.ext_i(ext3), .out_i(p3o), .oe_i(p3e), .pull_i(p3u), .lvl_o(p3l));
  iopc_board #(.W(8)) b5 (.ext_i(ext5), .out_i(p5o), .oe_i(p5e), .pull_i(p5u), .lvl_o(p5l));
  initial forever #20 mclk_i = ~mclk_i;
  // One bus transfer, then time for the pins to follow
  task bus(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wd <= {24'h000000, d};
    do @(posedge mclk_i); while (wq !== 1'b0);
    q = rdat[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    repeat (2) @(negedge mclk_i);
  endtask
  task rchk(input logic [15:0] a, input logic [7:0] e, input string n);
    bus(1'b0, a, 8'h00);
    `CHK(n, e, q)
  endtask
  task t_reset;
    rchk(16'hFFD8, 8'h00, "p5 data");
    rchk(16'hFFEF, 8'h00, "p5 pull");
    rchk(16'hFFE8, 8'hFF, "p5 dir");
    rchk(16'h0100, 8'h00, "unmapped");
    $display("test reset done");
  endtask
  task t_p5;
    @(posedge mclk_i);
    ext5 <= 8'h3C;
    bus(1'b1, 16'hFFE8, 8'hF0);
    bus(1'b1, 16'hFFD8, 8'hA5);
    `CHK("p5 oe", 8'hF0, p5e)
    `CHK("p5 out", 8'hA0, p5o & 8'hF0)
    rchk(16'hFFD8, 8'hAC, "p5 mixed");
    bus(1'b1, 16'hFFEF, 8'hFF);
    `CHK("p5 pullup", 8'h0F, p5u)
    rchk(16'hFFEF, 8'hFF, "p5 pull rd");
    rchk(16'hFFE8, 8'hFF, "p5 dir rd");
    bus(1'b1, 16'hFFEF, 8'h00);
    $display("test port5 done");
  endtask
  task t_p3;
    @(posedge mclk_i);
    stx <= 3'h4;
    bus(1'b1, 16'hFFE6, 8'h07);
    bus(1'b1, 16'hFFD6, 8'h02);
    `CHK("p3 gpio", 6'h3A, {p3e, p3o})
    bus(1'b1, 16'hFFF0, 8'h00);
    bus(1'b1, 16'hFFFD, 8'h07);
    `CHK("p3 serial", 5'h16, {p3e, p3o[2], p3o[0]})
    @(posedge mclk_i);
    stx <= 3'h5;
    ext3 <= 3'h3;
    bus(1'b1, 16'hFFF0, 8'h01);
    bus(1'b1, 16'hFFE6, 8'h00);
    `CHK("p3 clk in", 3'h4, p3e)
    `CHK("serial rx", 2'h3, srx)
    @(posedge mclk_i);
    ext3 <= 3'h2;
    bus(1'b1, 16'hFFFD, 8'h00);
    bus(1'b1, 16'hFFEE, 8'h01);
    `CHK("p3 pullup", 3'h1, p3u)
    rchk(16'hFFD6, 8'h03, "p3 pins");
    bus(1'b1, 16'hFFE6, 8'h01);
    `CHK("p3 pull off", 3'h0, p3u)
    rchk(16'hFFD6, 8'h02, "p3 mixed");
    $display("test port3 done");
  endtask
  task t_modes;
    bus(1'b1, 16'hFFD6, 8'h01);
    bus(1'b1, 16'hFFF4, 8'h04);
    bus(1'b1, 16'hFFD6, 8'h00);
    `CHK("sleep hold", 1'b1, p3o[0])
    bus(1'b1, 16'hFFF4, 8'h01);
    `CHK("active", 1'b0, p3o[0])
    bus(1'b1, 16'hFFE6, 8'h00);
    bus(1'b1, 16'hFFF4, 8'h20);
    `CHK("standby p3", 4'h3, {p3e, p3o[0]})
    `CHK("standby p5", 8'h00, p5e)
    bus(1'b1, 16'hFFF4, 8'h01);
    $display("test modes done");
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge mclk_i);
    `CHK("reset hiz", 11'h000, {p3e, p5e})
    rstn_i <= 1'b1;
    t_reset;
    t_p5;
    t_p3;
    t_modes;
    test_done;
  end
  // Hang guard
  initial begin
    #100000;
    err_total++;
    test_done;
  end
endmodule // iopc_port_tb_top
